//--- core/tia_pkg.sv
// Purpose: shared constants and types of the two-tier interrupt aggregator
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   register index times four gives the byte address
package tia_pkg;

    // register indices (byte address = index * 4)
    localparam logic [5:0] IDX_ALERT_CONTROL = 6'h09;
    localparam logic [5:0] IDX_SOURCE_MASK   = 6'h0A;
    localparam logic [5:0] IDX_PENDING_FLAGS = 6'h0B;
    localparam logic [5:0] IDX_GPIO_ENABLE   = 6'h0C;
    localparam logic [5:0] IDX_PIN_EVENTS    = 6'h0D;
    localparam logic [5:0] IDX_SYS_STATUS    = 6'h10;
    localparam logic [5:0] IDX_SYS_MASK      = 6'h11;

    // reset values
    localparam logic [7:0] RST_ALERT_CONTROL = 8'h00;
    localparam logic [7:0] RST_SOURCE_MASK   = 8'h00;
    localparam logic [7:0] RST_PENDING_FLAGS = 8'h10;
    localparam logic [7:0] RST_GPIO_ENABLE   = 8'h00;
    localparam logic [7:0] RST_PIN_EVENTS    = 8'h00;
    localparam logic [1:0] RST_SYS_STATUS    = 2'h0;
    localparam logic [1:0] RST_SYS_MASK      = 2'h0;

    // pending flag positions
    localparam int PF_CONTACT  = 0;
    localparam int PF_MARK     = 1;
    localparam int PF_OVERRUN  = 2;
    localparam int PF_FULL     = 3;
    localparam int PF_EMPTY    = 4;
    localparam int PF_TEMP     = 5;
    localparam int PF_ADC      = 6;
    localparam int PF_GPIO     = 7;

    // alert_control field positions
    localparam int AC_MASTER   = 0;
    localparam int AC_EDGE     = 1;
    localparam int AC_POLARITY = 2;

    // local status positions
    localparam int SS_ALERT_RAISED = 0;
    localparam int SS_FLAGS_CLEARED = 1;

    // edge-mode alert pulse width
    localparam int ALERT_PULSE_NS = 1000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int ALERT_PULSE_CYC_I = ALERT_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ALERT_PULSE_CYC = ALERT_PULSE_CYC_I[7:0];

    // touch data queue status from the touch controller
    typedef struct packed {
        logic       empty;
        logic       full;
        logic       overrun;
        logic [7:0] level;
        logic [7:0] threshold;
    } tia_queue_t;

    // alert_control layout
    typedef struct packed {
        logic [4:0] reserved;
        logic       polarity;
        logic       edge_sel;
        logic       master_en;
    } tia_alert_ctrl_t;

endpackage

//--- core/tia_aggregator.sv
// Purpose: top-tier interrupt aggregation and host alert pin generation
// Assumes: all event inputs come from logic on sys_clk; AHB-Lite slave, words only
// Notes:   reads take one wait state so they always see committed writes
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps

module tia_aggregator (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // event sources
    input  wire tia_pkg::tia_queue_t  queue_stat,
    input  wire logic                 contact_detected,
    input  wire logic                 temperature_limit_event,
    input  wire logic                 adc_enabled_active,
    input  wire logic [7:0]           gpio_pin_event,
    // host alert pin and local interrupt
    output logic                      alert_pin,
    output logic                      sys_irq
);

    // overview: three host-visible registers of the top tier, two of the
    // gpio second tier, and a local status and mask pair that drive an
    // interrupt toward the on-chip processor
    // every event input is a pulse or level of the sys_clk domain, so no
    // synchroniser sits in front of them; a source from another clock must
    // be brought across before it reaches this block
    //
    // register state
    tia_pkg::tia_alert_ctrl_t ctrl_r;
    logic [7:0]  source_mask_r;
    logic [7:0]  pending_flags_r;
    logic [7:0]  pending_flags_nxt;
    logic [7:0]  gpio_enable_r;
    logic [7:0]  pin_event_flags_r;
    logic [7:0]  pin_event_flags_nxt;
    logic [1:0]  sys_status_r;
    logic [1:0]  sys_status_nxt;
    logic [1:0]  sys_mask_r;

    // bus data-phase state
    logic        dp_valid_r;
    logic        dp_write_r;
    logic [5:0]  dp_index_r;
    logic        dp_mapped_r;
    logic        rd_wait_r;
    logic [31:0] rdata_r;

    // event detection state
    logic        empty_prev_r;
    logic        full_prev_r;
    logic        mark_prev_r;
    logic [7:0]  armed_prev_r;
    logic [7:0]  pulse_cnt_r;
    logic        alert_act_prev_r;
    logic        alert_pin_r;

    // combinational helpers
    logic        addr_take;
    logic        wr_go;
    logic        rd_cap;
    logic [7:0]  wbyte;
    logic        at_mark;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic [7:0]  armed;
    logic [7:0]  new_armed;
    logic        alert_act;
    logic [31:0] rd_mux;

    // bus timing in short: a write finishes in its first data-phase cycle,
    // a read waits one cycle so the read mux sees any write just ahead of it
    // the wait state costs one cycle per read, traded for a simpler mux path
    // and no write-to-read forwarding logic
    //
    // address phase is taken only when the bus is ready and a transfer starts
    assign addr_take = hsel && htrans[1] && hready;
    assign wr_go     = dp_valid_r && dp_write_r && dp_mapped_r;
    assign rd_cap    = dp_valid_r && !dp_write_r && rd_wait_r;
    assign wbyte     = hwdata[7:0];

    // reads stall one cycle; writes complete at once
    assign hreadyout = !rd_cap;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    // data phase tracking
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dp_valid_r  <= 1'b0;
            dp_write_r  <= 1'b0;
            dp_index_r  <= 6'h00;
            dp_mapped_r <= 1'b0;
            rd_wait_r   <= 1'b0;
        end else if (rd_cap) begin
            rd_wait_r <= 1'b0; // answer stands next cycle
        end else begin
            dp_valid_r  <= addr_take;
            dp_write_r  <= hwrite;
            dp_index_r  <= haddr[7:2];
            dp_mapped_r <= (haddr[1:0] == 2'h0);
            rd_wait_r   <= addr_take && !hwrite;
        end
    end

    // the mux works from the registered index, never from haddr, because the
    // address bus may already carry the next transfer during the wait state
    // upper bits of every word read as zero
    //
    // read data mux; unmapped or misaligned words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dp_mapped_r) begin
            unique case (dp_index_r)
                tia_pkg::IDX_ALERT_CONTROL: rd_mux[2:0] = ctrl_r[2:0];
                tia_pkg::IDX_SOURCE_MASK:   rd_mux[7:0] = source_mask_r;
                tia_pkg::IDX_PENDING_FLAGS: rd_mux[7:0] = pending_flags_r;
                tia_pkg::IDX_GPIO_ENABLE:   rd_mux[7:0] = gpio_enable_r;
                tia_pkg::IDX_PIN_EVENTS:    rd_mux[7:0] = pin_event_flags_r;
                tia_pkg::IDX_SYS_STATUS:    rd_mux[1:0] = sys_status_r;
                tia_pkg::IDX_SYS_MASK:      rd_mux[1:0] = sys_mask_r;
                default:                    rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // read data register, loaded after any write ahead of it has landed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_cap) begin
            rdata_r <= rd_mux;
        end
    end

    // plain read/write configuration registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r        <= tia_pkg::RST_ALERT_CONTROL;
            source_mask_r <= tia_pkg::RST_SOURCE_MASK;
            gpio_enable_r <= tia_pkg::RST_GPIO_ENABLE;
            sys_mask_r    <= tia_pkg::RST_SYS_MASK;
        end else if (wr_go) begin
            if (dp_index_r == tia_pkg::IDX_ALERT_CONTROL) begin
                ctrl_r <= {5'h00, wbyte[2:0]}; // reserved bits stay zero
            end
            if (dp_index_r == tia_pkg::IDX_SOURCE_MASK) begin
                source_mask_r <= wbyte;
            end
            if (dp_index_r == tia_pkg::IDX_GPIO_ENABLE) begin
                gpio_enable_r <= wbyte;
            end
            if (dp_index_r == tia_pkg::IDX_SYS_MASK) begin
                sys_mask_r <= wbyte[1:0];
            end
        end
    end

    // queue empty, full and mark arrive as levels; the flags want the moment they start,
    // so each one is compared with its value one cycle earlier
    // a level that stays high therefore sets its flag once, and a host that
    // clears the flag will not see it again until the level drops and returns
    //
    // queue level mark: level at or above threshold
    assign at_mark = (queue_stat.level >= queue_stat.threshold);

    // edge memory for level-type queue conditions
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            empty_prev_r <= 1'b1; // reset flag already reports empty
            full_prev_r  <= 1'b0;
            mark_prev_r  <= 1'b0;
        end else begin
            empty_prev_r <= queue_stat.empty;
            full_prev_r  <= queue_stat.full;
            mark_prev_r  <= at_mark;
        end
    end

    // pending flag causes; set regardless of the source mask
    always_comb begin
        set_vec = 8'h00;
        set_vec[tia_pkg::PF_CONTACT] = contact_detected;
        set_vec[tia_pkg::PF_MARK]    = at_mark && !mark_prev_r;
        set_vec[tia_pkg::PF_OVERRUN] = queue_stat.overrun;
        set_vec[tia_pkg::PF_FULL]    = queue_stat.full && !full_prev_r;
        set_vec[tia_pkg::PF_EMPTY]   = queue_stat.empty && !empty_prev_r;
        set_vec[tia_pkg::PF_TEMP]    = temperature_limit_event;
        set_vec[tia_pkg::PF_ADC]     = adc_enabled_active;
        set_vec[tia_pkg::PF_GPIO]    = |(pin_event_flags_r & gpio_enable_r);
    end

    // the host services a cause and then writes its bit back as one;
    // zero bits in the same word leave other flags alone, so a host can
    // clear one cause without a read-modify-write race
    //
    // write-one-to-clear mask for the pending flags
    assign clr_vec = (wr_go && dp_index_r == tia_pkg::IDX_PENDING_FLAGS) ? wbyte : 8'h00;

    // a cause in the same cycle as its clear wins, so no event is lost
    assign pending_flags_nxt = set_vec | (pending_flags_r & ~clr_vec);

    // top-tier pending flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pending_flags_r <= tia_pkg::RST_PENDING_FLAGS;
        end else begin
            pending_flags_r <= pending_flags_nxt;
        end
    end

    // second-tier per-pin GPIO flags, write one to clear, set wins
    assign pin_event_flags_nxt = gpio_pin_event |
        (pin_event_flags_r &
         ~((wr_go && dp_index_r == tia_pkg::IDX_PIN_EVENTS) ? wbyte : 8'h00));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_event_flags_r <= tia_pkg::RST_PIN_EVENTS;
        end else begin
            pin_event_flags_r <= pin_event_flags_nxt;
        end
    end

    // the mask only gates the pin, never the flags themselves, so software
    // may poll masked causes at leisure
    // new_armed compares with the previous cycle: a flag that becomes
    // unmasked while already pending counts as a new event in edge mode
    //
    // flags that are both pending and let through by the mask
    assign armed     = pending_flags_r & source_mask_r;
    assign new_armed = armed & ~armed_prev_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed_prev_r <= 8'h00;
        end else begin
            armed_prev_r <= armed;
        end
    end

    // limitation: events that arrive while a pulse is still running merge
    // into one longer pulse, so an edge host may count fewer than happened;
    // it must read the pending flags to find every cause
    // the pulse width is a package constant sized for slow host sampling
    //
    // edge-mode pulse timer; a new event restarts it, the master bit kills it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_r <= 8'h00;
        end else if (!ctrl_r.master_en) begin
            pulse_cnt_r <= 8'h00;
        end else if (|new_armed) begin
            pulse_cnt_r <= tia_pkg::ALERT_PULSE_CYC;
        end else if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
        end
    end

    // active state of the alert before polarity is applied
    always_comb begin
        if (!ctrl_r.master_en) begin
            alert_act = 1'b0;
        end else if (ctrl_r.edge_sel) begin
            alert_act = (pulse_cnt_r != 8'h00);
        end else begin
            alert_act = |armed;
        end
    end

    // pin driven from a flop; inactive level follows the polarity bit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            alert_pin_r <= 1'b1; // low-active at reset, so idle is high
        end else begin
            alert_pin_r <= ctrl_r.polarity ? alert_act : !alert_act;
        end
    end

    assign alert_pin = alert_pin_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            alert_act_prev_r <= 1'b0;
        end else begin
            alert_act_prev_r <= alert_act;
        end
    end

    // the local status records alert activity and host clears, so the on-chip
    // processor can follow what the host side does without polling it
    // the read that clears it is the one whose data is being loaded, so the
    // value returned is the value cleared and no event slips between them
    //
    // local status: cleared by reading it, a new event in that cycle wins
    always_comb begin
        sys_status_nxt = sys_status_r;
        if (rd_cap && dp_mapped_r && dp_index_r == tia_pkg::IDX_SYS_STATUS) begin
            sys_status_nxt = 2'h0;
        end
        if (alert_act && !alert_act_prev_r) begin
            sys_status_nxt[tia_pkg::SS_ALERT_RAISED] = 1'b1;
        end
        if (|(clr_vec & pending_flags_r)) begin
            sys_status_nxt[tia_pkg::SS_FLAGS_CLEARED] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sys_status_r <= tia_pkg::RST_SYS_STATUS;
        end else begin
            sys_status_r <= sys_status_nxt;
        end
    end

    // local level interrupt toward the on-chip processor
    assign sys_irq = |(sys_status_r & sys_mask_r);

endmodule

//--- verification/tia_assertions.sv
// Purpose: port-level checks of the interrupt aggregator
// Assumes: bus hready is looped from hreadyout
// Notes:   control and mask are shadowed from committed bus writes
`timescale 1ns/1ps
module tia_checker (
    // clock, reset and bus
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // event sources and pin
    input wire tia_pkg::tia_queue_t queue_stat,
    input wire logic        contact_detected,
    input wire logic        temperature_limit_event,
    input wire logic        adc_enabled_active,
    input wire logic        alert_pin
);
    logic       wdp_r;
    logic [7:0] wa_r;
    logic [2:0] ctl_r;
    logic [7:0] mask_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // writes commit at the end of their data phase, same edge as the design
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdp_r  <= 1'b0;
            wa_r   <= 8'h00;
            ctl_r  <= 3'h0;
            mask_r <= 8'h00;
        end else begin
            if (hready) begin
                wdp_r <= hsel && htrans[1] && hwrite;
                wa_r  <= haddr;
            end
            if (wdp_r && hready && wa_r == 8'h24) ctl_r <= hwdata[2:0];
            if (wdp_r && hready && wa_r == 8'h28) mask_r <= hwdata[7:0];
        end
    end
    // an unmasked cause in level mode reaches the pin two edges later
    property ev_alert(ev, int b);
        ctl_r[0] && !ctl_r[1] && mask_r[b] && ev ##1 $stable(ctl_r) && mask_r[b]
            |=> alert_pin == $past(ctl_r[2]);
    endproperty
    touch_alert_a: assert property (ev_alert(contact_detected, 0))
        else $error("touch did not raise the alert");
    temp_alert_a: assert property (ev_alert(temperature_limit_event, 5))
        else $error("temperature event did not raise the alert");
    adc_alert_a: assert property (ev_alert(adc_enabled_active, 6))
        else $error("adc summary did not raise the alert");
    overrun_alert_a: assert property (ev_alert(queue_stat.overrun, 2))
        else $error("overrun did not raise the alert");
    master_off_a: assert property (!ctl_r[0] |=> alert_pin == !$past(ctl_r[2]))
        else $error("alert active while master enable is off");
    level_hold_a: assert property (!wdp_r ##1 (ctl_r[0] && !ctl_r[1] &&
        alert_pin == ctl_r[2]) |=> alert_pin == $past(ctl_r[2]))
        else $error("level alert dropped without a write");
    read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response other than okay");
    cover property (ctl_r[0] && ctl_r[1] && alert_pin == ctl_r[2]);
    cover property (ctl_r[0] && !ctl_r[1] && alert_pin == ctl_r[2]);
    cover property (wdp_r && wa_r == 8'h2C);
endmodule
bind tia_aggregator tia_checker u_chk (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hreadyout, .hresp, .queue_stat, .contact_detected,
    .temperature_limit_event, .adc_enabled_active, .alert_pin);

//--- verification/tia_host_model.sv
// Purpose: host that watches the alert pin
// Assumes: host is told the programmed sense
// Notes:   counts active-going transitions, as an edge-sensitive host would
`timescale 1ns/1ps
module tia_host_model (
    // clock and pin
    input  wire logic   sys_clk,
    input  wire logic   alert_pin,
    // sense and count
    input  wire logic   pol,
    output logic [15:0] hits
);
    logic        prev_r;
    logic [15:0] cnt_r = 16'h0000;
    // one driver for the count; the port only mirrors it
    assign hits = cnt_r;
    // a transition toward the active level counts as one notification
    always @(posedge sys_clk) begin
        if (alert_pin === pol && prev_r === !pol) cnt_r <= cnt_r + 16'h0001;
        prev_r <= alert_pin;
    end
endmodule

//--- verification/two_tier_interrupt_aggregator_test.sv
// Purpose: self-checking bench of the interrupt aggregator
// Assumes: one AHB-Lite master, hready looped from hreadyout
// Notes:   queue mark fixed at 4; causes driven as one-cycle pulses, the mark also as a held level
`timescale 1ns/1ps
module two_tier_interrupt_aggregator_test;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  ev_r = 8'h00;
    logic [7:0]  gmask = 8'h01;
    logic        hold = 1'b0;
    logic        pol = 1'b1;
    logic        hreadyout, hresp, alert_pin, sys_irq;
    logic [31:0] hrdata, q;
    logic [15:0] hits, h0;
    logic [7:0]  r, m;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 32'hd040eedb;
    int          i;
    tia_pkg::tia_queue_t qs;
    // queue status derived from the pulse vector; level 5 above, 3 below the mark
    assign qs = '{empty: !ev_r[4], full: ev_r[3], overrun: ev_r[2],
                  level: hold ? 8'h05 : (ev_r[1] ? 8'h04 : 8'h03), threshold: 8'h04};
    always #10 sys_clk = ~sys_clk;
    tia_aggregator uut (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .queue_stat(qs),
        .contact_detected(ev_r[0]), .temperature_limit_event(ev_r[5]),
        .adc_enabled_active(ev_r[6]), .gpio_pin_event(ev_r[7] ? gmask : 8'h00),
        .alert_pin, .sys_irq);
    tia_host_model host (.sys_clk, .alert_pin, .pol, .hits);
    // only the direct causes of a random burst may show up
    function automatic logic [7:0] flags_exp(input logic [7:0] v);
        return v & 8'h65;
    endfunction
    // one single transfer, waiting for hready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        cmp(q, {24'h000000, exp});
    endtask
    // pulse causes for one cycle, then let flags and pin settle
    task automatic fire(input logic [7:0] v);
        ev_r <= v;
        @(posedge sys_clk);
        ev_r <= 8'h00;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hang counts as a failure
    initial begin
        #(20 * 40000);
        n_fail++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'h24, 8'h00);
        rd(8'h2C, 8'h10);
        rd(8'h3C, 8'h00);
        bus(1'b1, 8'h2C, 8'h00);
        rd(8'h2C, 8'h10);
        bus(1'b1, 8'h2C, 8'h10);
        rd(8'h2C, 8'h00);
        $display("test reset_and_clear done");
        bus(1'b1, 8'h30, 8'h01);
        for (i = 0; i < 8; i++) begin
            fire(8'h01 << i);
            rd(8'h2C, 8'h01 << i);
            bus(1'b1, 8'h34, 8'hFF);
            bus(1'b1, 8'h2C, 8'hFF);
        end
        $display("test each_cause done");
        hold <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(8'h2C, 8'h02);
        bus(1'b1, 8'h2C, 8'h02);
        repeat (3) @(posedge sys_clk);
        rd(8'h2C, 8'h00);
        hold <= 1'b0;
        @(posedge sys_clk);
        fire(8'h02);
        gmask <= 8'h02;
        fire(8'h80);
        rd(8'h2C, 8'h02);
        rd(8'h34, 8'h02);
        bus(1'b1, 8'h34, 8'hFF);
        bus(1'b1, 8'h2C, 8'hFF);
        bus(1'b0, 8'h40, 8'h00);
        $display("test mark_and_pins done");
        bus(1'b1, 8'h44, 8'h01);
        bus(1'b1, 8'h28, 8'h01);
        bus(1'b1, 8'h24, 8'h05);
        fire(8'h01);
        cmp(alert_pin, 1'b1);
        cmp(sys_irq, 1'b1);
        rd(8'h40, 8'h01);
        cmp(sys_irq, 1'b0);
        bus(1'b1, 8'h2C, 8'h01);
        repeat (2) @(posedge sys_clk);
        cmp(alert_pin, 1'b0);
        bus(1'b1, 8'h28, 8'h00);
        fire(8'h01);
        cmp(alert_pin, 1'b0);
        bus(1'b1, 8'h28, 8'h01);
        repeat (2) @(posedge sys_clk);
        cmp(alert_pin, 1'b1);
        bus(1'b1, 8'h24, 8'h01);
        repeat (2) @(posedge sys_clk);
        cmp(alert_pin, 1'b0);
        bus(1'b1, 8'h24, 8'h00);
        repeat (2) @(posedge sys_clk);
        cmp(alert_pin, 1'b1);
        bus(1'b1, 8'h2C, 8'hFF);
        bus(1'b1, 8'h24, 8'h07);
        h0 = hits;
        fire(8'h01);
        cmp(alert_pin, 1'b1);
        repeat (55) @(posedge sys_clk);
        cmp(alert_pin, 1'b0);
        cmp(hits, h0 + 16'h0001);
        $display("test alert_pin done");
        for (i = 0; i < 24; i++) begin
            r = 8'($random(seed));
            m = 8'($random(seed));
            bus(1'b1, 8'h2C, 8'hFF);
            bus(1'b1, 8'h28, m);
            bus(1'b1, 8'h24, {5'h00, m[2:0]});
            fire(r & 8'h65);
            rd(8'h2C, flags_exp(r));
        end
        $display("test random_bursts done");
        tally_and_finish();
    end
endmodule
